//--- core/adc_cfg_pkg.sv
// Constants shared by the converter sequence and configuration block.
package adc_cfg_pkg;
	// ----------------------------------------------------------------
	// Register indices on the plain register port
	// ----------------------------------------------------------------
	localparam logic [3:0] SEQ_CONTROL_IDX = 4'h0;
	localparam logic [3:0] CLOCK_TIMING_IDX = 4'h1;
	localparam logic [3:0] INPUT_SELECT_IDX = 4'h2;
	localparam logic [3:0] PIN_MODE_LOW_IDX = 4'h3;
	localparam logic [3:0] PIN_MODE_HIGH_IDX = 4'h4;
	localparam logic [3:0] SCAN_SELECT_IDX = 4'h5;
	localparam logic [3:0] IRQ_STATUS_IDX = 4'h6;
	localparam logic [3:0] IRQ_MASK_IDX = 4'h7;

	// ----------------------------------------------------------------
	// Writable bit masks; reserved and unimplemented bits stay zero
	// ----------------------------------------------------------------
	localparam logic [15:0] SEQ_CONTROL_WMASK = 16'he43f;
	localparam logic [15:0] CLOCK_TIMING_WMASK = 16'h9fff;
	localparam logic [15:0] INPUT_SELECT_WMASK = 16'h9f9f;
	localparam logic [15:0] PIN_MODE_HIGH_WMASK = 16'h0003;
	localparam logic [15:0] IRQ_WMASK = 16'h0003;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int REF_CONFIG_LSB = 13;
	localparam int SCAN_ENABLE_BIT = 10;
	localparam int FILL_HALF_BIT = 7;
	localparam int SEQ_PER_IRQ_LSB = 2;
	localparam int SPLIT_MODE_BIT = 1;
	localparam int ALT_SAMPLE_BIT = 0;
	localparam int CLOCK_SOURCE_BIT = 15;
	localparam int SAMPLE_TIME_LSB = 8;
	localparam int DIVIDER_LSB = 0;
	localparam int NEG_B_BIT = 15;
	localparam int POS_B_LSB = 8;
	localparam int NEG_A_BIT = 7;
	localparam int POS_A_LSB = 0;
	localparam int BANDGAP_DIS_BIT = 1;
	localparam int HALF_BANDGAP_DIS_BIT = 0;
	localparam int EV_SEQ_DONE_BIT = 0;
	localparam int EV_BAD_CODE_BIT = 1;

	// ----------------------------------------------------------------
	// Encodings and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] REF_AVDD_AVSS = 3'h0;
	localparam logic [2:0] REF_EXTP_AVSS = 3'h1;
	localparam logic [2:0] REF_AVDD_EXTN = 3'h2;
	localparam logic [2:0] REF_EXTP_EXTN = 3'h3;
	localparam logic [4:0] CODE_HALF_BANDGAP = 5'h10;
	localparam logic [4:0] CODE_BANDGAP = 5'h11;
	localparam logic [4:0] CODE_LAST_LEGAL = 5'h11;
	localparam int OSC_PER_INSTR = 2;
	localparam int SCAN_CHANNELS = 18;
endpackage

//--- core/adc_sequence_config.sv
// Converter configuration registers, input scanning, buffer fill and interrupt sequencing.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns

// What this block does
// - Three-bit reference field picks supply rails or external references for both ends.
// - Scan enable steps the set-A positive input through selected scan channels.
// - In split mode the fill bit reads 1 while filling the upper eight words.
// - Interrupt after every Nth sequence, N being the rate field plus one.
// - Split mode makes two alternating 8-word halves, else one 16-word buffer.
// - Alternate mode uses set A first, then B and A in turn.
// - Instruction cycle equals two oscillator periods.
// - Positive codes 0 to 15 pick inputs 0 to 15, code 17 the band gap.
// - Pin bit 1 makes the pin digital, 0 analog and sampled.
// - High pin bit 1 set removes the band gap channel from scanning.
// - High pin bit 0 set removes the half band gap channel from scanning.
// - Each scan select bit adds its channel to the scan.
module adc_sequence_config
(
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [15:0] RDATA_O,
	input  wire logic        RC_TICK_I,
	input  wire logic        SAMPLE_START_I,
	input  wire logic        CONV_DONE_I,
	output logic             TAD_TICK_O,
	output logic             SAMPLE_END_O,
	output logic             REF_POS_EXT_O,
	output logic             REF_NEG_EXT_O,
	output logic      [4:0]  POS_INPUT_O,
	output logic             NEG_INPUT_AN1_O,
	output logic      [15:0] PIN_DIGITAL_O,
	output logic      [3:0]  BUF_WR_ADDR_O,
	output logic             BUF_FILL_HALF_O,
	output logic             IRQ_O
);
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [15:0] seq_r, seq_nxt, clk_r, clk_nxt, sel_r, sel_nxt;
	logic [15:0] pinl_r, pinl_nxt, pinh_r, pinh_nxt, scan_r, scan_nxt;
	logic [15:0] stat_r, stat_nxt, mask_r, mask_nxt, rdata_r, rdata_nxt;
	logic [15:0] events;
	logic        wr_sel, wr_bad;
	// Field views.
	logic [2:0] reference_config;
	logic       scan_enable, buffer_split_mode, alternate_sample_enable, conv_clock_source;
	logic [3:0] sequences_per_interrupt;
	logic [4:0] auto_sample_time, positive_input_set_a, positive_input_set_b;
	logic [7:0] conv_clock_divider;
	logic       negative_input_set_a, negative_input_set_b;
	assign reference_config = seq_r[adc_cfg_pkg::REF_CONFIG_LSB +: 3];
	assign scan_enable = seq_r[adc_cfg_pkg::SCAN_ENABLE_BIT];
	assign sequences_per_interrupt = seq_r[adc_cfg_pkg::SEQ_PER_IRQ_LSB +: 4];
	assign buffer_split_mode = seq_r[adc_cfg_pkg::SPLIT_MODE_BIT];
	assign alternate_sample_enable = seq_r[adc_cfg_pkg::ALT_SAMPLE_BIT];
	assign conv_clock_source = clk_r[adc_cfg_pkg::CLOCK_SOURCE_BIT];
	assign auto_sample_time = clk_r[adc_cfg_pkg::SAMPLE_TIME_LSB +: 5];
	assign conv_clock_divider = clk_r[adc_cfg_pkg::DIVIDER_LSB +: 8];
	assign positive_input_set_a = sel_r[adc_cfg_pkg::POS_A_LSB +: 5];
	assign positive_input_set_b = sel_r[adc_cfg_pkg::POS_B_LSB +: 5];
	assign negative_input_set_a = sel_r[adc_cfg_pkg::NEG_A_BIT];
	assign negative_input_set_b = sel_r[adc_cfg_pkg::NEG_B_BIT];
	// Sequencing state used by the read path and the event logic.
	logic [3:0] seq_cnt_r, seq_cnt_nxt, wr_ptr_r, wr_ptr_nxt;
	logic       alt_b_r, alt_b_nxt, restart_r, restart_nxt, irq_event;
	logic [4:0] scan_ch_r, scan_ch_nxt;
	// Writes mask reserved bits to zero; the fill bit is read-only.
	// A read of the status register clears it, but a new event still wins.
	always_comb
	begin
		seq_nxt = seq_r;
		clk_nxt = clk_r;
		sel_nxt = sel_r;
		pinl_nxt = pinl_r;
		pinh_nxt = pinh_r;
		scan_nxt = scan_r;
		mask_nxt = mask_r;
		stat_nxt = stat_r;
		wr_sel = WR_I && (ADDR_I == adc_cfg_pkg::INPUT_SELECT_IDX);
		if (WR_I)
		begin
			unique case (ADDR_I)
				adc_cfg_pkg::SEQ_CONTROL_IDX: seq_nxt = WDATA_I & adc_cfg_pkg::SEQ_CONTROL_WMASK;
				adc_cfg_pkg::CLOCK_TIMING_IDX: clk_nxt = WDATA_I & adc_cfg_pkg::CLOCK_TIMING_WMASK;
				adc_cfg_pkg::INPUT_SELECT_IDX: sel_nxt = WDATA_I & adc_cfg_pkg::INPUT_SELECT_WMASK;
				adc_cfg_pkg::PIN_MODE_LOW_IDX: pinl_nxt = WDATA_I;
				adc_cfg_pkg::PIN_MODE_HIGH_IDX: pinh_nxt = WDATA_I & adc_cfg_pkg::PIN_MODE_HIGH_WMASK;
				adc_cfg_pkg::SCAN_SELECT_IDX: scan_nxt = WDATA_I;
				adc_cfg_pkg::IRQ_MASK_IDX: mask_nxt = WDATA_I & adc_cfg_pkg::IRQ_WMASK;
				default: ;
			endcase
		end
		// Codes above the band gap have no input behind them; flag such a write.
		wr_bad = wr_sel && ((WDATA_I[adc_cfg_pkg::POS_A_LSB +: 5] > adc_cfg_pkg::CODE_LAST_LEGAL)
			|| (WDATA_I[adc_cfg_pkg::POS_B_LSB +: 5] > adc_cfg_pkg::CODE_LAST_LEGAL));
		events = 16'h0000;
		events[adc_cfg_pkg::EV_SEQ_DONE_BIT] = irq_event;
		events[adc_cfg_pkg::EV_BAD_CODE_BIT] = wr_bad;
		if (RD_I && (ADDR_I == adc_cfg_pkg::IRQ_STATUS_IDX))
			stat_nxt = 16'h0000;
		stat_nxt = stat_nxt | events;
		rdata_nxt = 16'h0000;
		if (RD_I)
		begin
			unique case (ADDR_I)
				adc_cfg_pkg::SEQ_CONTROL_IDX:
				begin
					rdata_nxt = seq_r;
					rdata_nxt[adc_cfg_pkg::FILL_HALF_BIT] = BUF_FILL_HALF_O;
				end
				adc_cfg_pkg::CLOCK_TIMING_IDX: rdata_nxt = clk_r;
				adc_cfg_pkg::INPUT_SELECT_IDX: rdata_nxt = sel_r;
				adc_cfg_pkg::PIN_MODE_LOW_IDX: rdata_nxt = pinl_r;
				adc_cfg_pkg::PIN_MODE_HIGH_IDX: rdata_nxt = pinh_r;
				adc_cfg_pkg::SCAN_SELECT_IDX: rdata_nxt = scan_r;
				adc_cfg_pkg::IRQ_STATUS_IDX: rdata_nxt = stat_r;
				adc_cfg_pkg::IRQ_MASK_IDX: rdata_nxt = mask_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	// Register stage for the register file.
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			seq_r <= adc_cfg_pkg::REG_RESET;
			clk_r <= adc_cfg_pkg::REG_RESET;
			sel_r <= adc_cfg_pkg::REG_RESET;
			pinl_r <= adc_cfg_pkg::REG_RESET;
			pinh_r <= adc_cfg_pkg::REG_RESET;
			scan_r <= adc_cfg_pkg::REG_RESET;
			stat_r <= adc_cfg_pkg::REG_RESET;
			mask_r <= adc_cfg_pkg::REG_RESET;
			rdata_r <= adc_cfg_pkg::REG_RESET;
		end
		else
		begin
			seq_r <= seq_nxt;
			clk_r <= clk_nxt;
			sel_r <= sel_nxt;
			pinl_r <= pinl_nxt;
			pinh_r <= pinh_nxt;
			scan_r <= scan_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Conversion clock and auto-sample timer
	// ----------------------------------------------------------------
	logic [8:0] div_cnt_r, div_cnt_nxt, div_last;
	logic [4:0] samp_cnt_r, samp_cnt_nxt;
	logic       sampling_r, sampling_nxt, samp_end;
	// Period is two oscillator cycles per instruction cycle times divider plus one.
	assign div_last = 9'((adc_cfg_pkg::OSC_PER_INSTR * (int'(conv_clock_divider) + 1)) - 1);
	// The RC tick replaces the divided clock; the divider then idles at zero.
	always_comb
	begin
		div_cnt_nxt = (conv_clock_source || (div_cnt_r >= div_last)) ? 9'h000 : div_cnt_r + 9'h001;
		TAD_TICK_O = conv_clock_source ? RC_TICK_I : (div_cnt_r >= div_last);
		// A zero sample time ends on the very next tick, which is why it is discouraged.
		samp_end = sampling_r && TAD_TICK_O && ((samp_cnt_r + 5'h01 >= auto_sample_time));
		sampling_nxt = sampling_r;
		samp_cnt_nxt = samp_cnt_r;
		if (SAMPLE_START_I)
		begin
			sampling_nxt = 1'b1;
			samp_cnt_nxt = 5'h00;
		end
		else if (samp_end)
			sampling_nxt = 1'b0;
		else if (sampling_r && TAD_TICK_O)
			samp_cnt_nxt = samp_cnt_r + 5'h01;
	end

	// Register stage for the timers.
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			div_cnt_r <= 9'h000;
			samp_cnt_r <= 5'h00;
			sampling_r <= 1'b0;
			SAMPLE_END_O <= 1'b0;
		end
		else
		begin
			div_cnt_r <= div_cnt_nxt;
			samp_cnt_r <= samp_cnt_nxt;
			sampling_r <= sampling_nxt;
			SAMPLE_END_O <= samp_end && !SAMPLE_START_I;
		end
	end

	// ----------------------------------------------------------------
	// Scan, alternation, buffer pointer and interrupt rate
	// ----------------------------------------------------------------
	logic [adc_cfg_pkg::SCAN_CHANNELS-1:0] scan_mask;
	logic [4:0] first_ch, next_ch, cur_ch;
	logic       next_found;
	// Band gap and half band gap join the scan unless their disable bits are set.
	assign scan_mask = {~pinh_r[adc_cfg_pkg::BANDGAP_DIS_BIT], ~pinh_r[adc_cfg_pkg::HALF_BANDGAP_DIS_BIT], scan_r};
	assign cur_ch = restart_r ? first_ch : scan_ch_r;
	// Lowest enabled channel, and the next enabled one above the current.
	always_comb
	begin
		first_ch = 5'h00;
		next_ch = 5'h00;
		next_found = 1'b0;
		for (int i = adc_cfg_pkg::SCAN_CHANNELS - 1; i >= 0; i--)
		begin
			if (scan_mask[i])
				first_ch = 5'(i);
			if (scan_mask[i] && (5'(i) > cur_ch))
			begin
				next_ch = 5'(i);
				next_found = 1'b1;
			end
		end
		if (!next_found)
			next_ch = first_ch;
	end

	// Each finished sequence advances the counters; the Nth one raises the event.
	always_comb
	begin
		irq_event = CONV_DONE_I && (seq_cnt_r == sequences_per_interrupt);
		seq_cnt_nxt = seq_cnt_r;
		wr_ptr_nxt = wr_ptr_r;
		alt_b_nxt = alt_b_r;
		scan_ch_nxt = cur_ch;
		restart_nxt = restart_r && !CONV_DONE_I;
		if (CONV_DONE_I)
		begin
			seq_cnt_nxt = irq_event ? 4'h0 : seq_cnt_r + 4'h1;
			wr_ptr_nxt = wr_ptr_r + 4'h1;
			if (!alt_b_r && scan_enable)
				scan_ch_nxt = next_ch;
			alt_b_nxt = alternate_sample_enable && !alt_b_r;
			if (irq_event)
			begin
				// Split mode swaps halves; single mode starts again at word zero.
				wr_ptr_nxt = buffer_split_mode ? {~wr_ptr_r[3], 3'h0} : 4'h0;
				alt_b_nxt = 1'b0;
				restart_nxt = 1'b1;
			end
			else if (buffer_split_mode)
				wr_ptr_nxt = {wr_ptr_r[3], wr_ptr_r[2:0] + 3'h1};
		end
	end

	// Register stage for sequencing; the scan starts from its lowest channel.
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			seq_cnt_r <= 4'h0;
			wr_ptr_r <= 4'h0;
			alt_b_r <= 1'b0;
			scan_ch_r <= 5'h00;
			restart_r <= 1'b1;
		end
		else
		begin
			seq_cnt_r <= seq_cnt_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			alt_b_r <= alt_b_nxt;
			scan_ch_r <= scan_ch_nxt;
			restart_r <= restart_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs toward the pins and the converter core
	// ----------------------------------------------------------------
	// References: 1xx falls back to the supply rails like 000.
	assign REF_POS_EXT_O = (reference_config == adc_cfg_pkg::REF_EXTP_AVSS)
		|| (reference_config == adc_cfg_pkg::REF_EXTP_EXTN);
	assign REF_NEG_EXT_O = (reference_config == adc_cfg_pkg::REF_AVDD_EXTN)
		|| (reference_config == adc_cfg_pkg::REF_EXTP_EXTN);
	// Both sets share one code space: 0-15 inputs, 17 band gap.
	assign POS_INPUT_O = alt_b_r ? positive_input_set_b : (scan_enable ? cur_ch : positive_input_set_a);
	assign NEG_INPUT_AN1_O = alt_b_r ? negative_input_set_b : negative_input_set_a;
	assign PIN_DIGITAL_O = pinl_r;
	assign BUF_WR_ADDR_O = wr_ptr_r;
	assign BUF_FILL_HALF_O = buffer_split_mode && wr_ptr_r[3];
	assign RDATA_O = rdata_r;
	assign IRQ_O = |(stat_r & mask_r);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	a_ref_select: assert property (REF_POS_EXT_O == (!reference_config[2] && reference_config[0]))
		else $error("positive reference selection wrong");
	a_scan_channel: assert property (scan_enable && !alt_b_r && (|scan_mask) |-> scan_mask[POS_INPUT_O])
		else $error("scan visited a disabled channel");
	a_bandgap_skip: assert property (scan_enable && !alt_b_r && pinh_r[1] && (|scan_r) |-> POS_INPUT_O != 5'h11)
		else $error("band gap scanned while disabled");
	a_irq_rate: assert property (CONV_DONE_I && seq_cnt_r == sequences_per_interrupt |=> stat_r[0])
		else $error("interrupt event missing at rate count");
	a_split_swap: assert property (irq_event && buffer_split_mode && !WR_I |=> BUF_FILL_HALF_O != $past(BUF_FILL_HALF_O))
		else $error("fill half did not swap");
	a_alt_order: assert property (CONV_DONE_I && !irq_event && alternate_sample_enable |=> alt_b_r != $past(alt_b_r))
		else $error("alternate sample order broken");
	a_alt_restart: assert property (irq_event |=> !alt_b_r && restart_r)
		else $error("sequence did not restart after interrupt");
	a_pin_mode: assert property (WR_I && ADDR_I == adc_cfg_pkg::PIN_MODE_LOW_IDX |=> PIN_DIGITAL_O == $past(WDATA_I))
		else $error("pin mode not applied");
	a_div_period: assert property (TAD_TICK_O && !conv_clock_source && conv_clock_divider == 8'h00 && !WR_I
		##1 !WR_I |-> !TAD_TICK_O ##1 TAD_TICK_O)
		else $error("conversion clock period wrong");
	a_status_clear: assert property (RD_I && ADDR_I == adc_cfg_pkg::IRQ_STATUS_IDX && !CONV_DONE_I && !WR_I
		|=> stat_r == 16'h0000)
		else $error("status not cleared by read");
	c_split_irq: cover property (irq_event && buffer_split_mode);
	c_alt_scan: cover property (CONV_DONE_I && alternate_sample_enable && scan_enable);
	c_sample_end: cover property (SAMPLE_END_O);
	c_bad_code: cover property (wr_bad);
endmodule

//--- sim/conv_core_model.sv
// Behavioural model of the sampling converter core that faces the sequencing block.
`timescale 1ns/1ns
module conv_core_model
#(
	parameter int RC_PERIOD = 5
)
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      rc_tick_o,
	output logic      sample_start_o,
	output logic      conv_done_o
);
	// ----------------------------------------------------------------
	// Internal RC oscillator
	// ----------------------------------------------------------------
	int rc_cnt = 0;

	// The RC clock runs free, so its phase has no relation to any request.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rc_cnt <= 0;
		else
			rc_cnt <= (rc_cnt == RC_PERIOD - 1) ? 0 : rc_cnt + 1;
	end
	assign rc_tick_o = (rc_cnt == RC_PERIOD - 1);

	initial
	begin
		sample_start_o = 1'b0;
		conv_done_o = 1'b0;
	end

	// ----------------------------------------------------------------
	// Converter requests
	// ----------------------------------------------------------------
	// One sample/convert sequence ends after a gap; a zero gap answers promptly.
	task automatic convert(input int gap);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		conv_done_o <= 1'b1;
		@(posedge clk_i);
		conv_done_o <= 1'b0;
	endtask

	// Start sampling just after an RC tick, so no tick shares the start cycle.
	task automatic start_sample();
		@(posedge clk_i iff rc_tick_o);
		sample_start_o <= 1'b1;
		@(posedge clk_i);
		sample_start_o <= 1'b0;
	endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the converter sequence and configuration block.
`timescale 1ns/1ns
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic [15:0] rdata, pin_dig, d;
	logic        rc_tick, s_start, c_done, tad, s_end, ref_p, ref_n, neg_an1, fill, irq;
	logic [4:0]  pos;
	logic [3:0]  wptr, idx;
	logic [15:0] exp_q[$];
	int          miscompares = 0;
	int          n_tests = 0;
	int          n, i;

	always #20 clk = ~clk;

	adc_sequence_config i_dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .RC_TICK_I(rc_tick), .SAMPLE_START_I(s_start), .CONV_DONE_I(c_done),
		.TAD_TICK_O(tad), .SAMPLE_END_O(s_end), .REF_POS_EXT_O(ref_p), .REF_NEG_EXT_O(ref_n),
		.POS_INPUT_O(pos), .NEG_INPUT_AN1_O(neg_an1), .PIN_DIGITAL_O(pin_dig), .BUF_WR_ADDR_O(wptr),
		.BUF_FILL_HALF_O(fill), .IRQ_O(irq));

	conv_core_model i_core (.clk_i(clk), .rst_i(rst), .rc_tick_o(rc_tick), .sample_start_o(s_start),
		.conv_done_o(c_done));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop();
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	function automatic logic [15:0] st(input logic i_, input logic f, input logic [3:0] p, input logic ng,
		input logic [4:0] c);
		return {4'h0, i_, f, p, ng, c};
	endfunction

	// Read data stand only in the cycle after the strobe, and are zero otherwise.
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk)
	begin
		if (rd_q)
			chk(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hdead);
		else if (!rst)
			chk(rdata, 16'h0000);
	end

	// ----------------------------------------------------------------
	// Register bus and sequencing tasks
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// The expected word is noted when the read is issued; the monitor compares it.
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(v);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
	endtask

	// Gaps are random so both prompt and slow converter answers occur.
	task automatic conv(input int k);
		repeat (k) i_core.convert(int'($urandom_range(0, 3)));
		@(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// Watchdog: far beyond the few hundred cycles the tests need
	// ----------------------------------------------------------------
	initial
	begin
		#(40 * 20000);
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(64856));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Reset values, then unmapped indices that read zero and ignore writes.
		for (n = 0; n < 8; n++)
			rd_reg(4'(n), adc_cfg_pkg::REG_RESET);
		wr_reg(4'h9, 16'hffff);
		rd_reg(4'h9, 16'h0000);
		rd_reg(4'hf, 16'h0000);
		// Random writes with legal codes; reserved bits must read back as zero.
		for (n = 0; n < 24; n++)
		begin
			i = int'($urandom_range(0, 6));
			idx = (i == 6) ? adc_cfg_pkg::IRQ_MASK_IDX : 4'(i);
			d = 16'($urandom);
			if (idx == adc_cfg_pkg::INPUT_SELECT_IDX)
				d = {d[15:13], 5'($urandom_range(0, 17)), d[7:5], 5'($urandom_range(0, 17))};
			if (idx == adc_cfg_pkg::CLOCK_TIMING_IDX)
				d[7:0] = 8'($urandom_range(0, 63));
			wr_reg(idx, d);
			case (idx)
				adc_cfg_pkg::SEQ_CONTROL_IDX: d = d & adc_cfg_pkg::SEQ_CONTROL_WMASK;
				adc_cfg_pkg::CLOCK_TIMING_IDX: d = d & adc_cfg_pkg::CLOCK_TIMING_WMASK;
				adc_cfg_pkg::INPUT_SELECT_IDX: d = d & adc_cfg_pkg::INPUT_SELECT_WMASK;
				adc_cfg_pkg::PIN_MODE_HIGH_IDX: d = d & adc_cfg_pkg::PIN_MODE_HIGH_WMASK;
				adc_cfg_pkg::IRQ_MASK_IDX: d = d & adc_cfg_pkg::IRQ_WMASK;
				default: d = d;
			endcase
			rd_reg(idx, d);
			if (idx == adc_cfg_pkg::PIN_MODE_LOW_IDX)
				chk(pin_dig, d);
		end
		// Every reference code, upper codes falling back to the supply rails.
		for (n = 0; n < 8; n++)
		begin
			wr_reg(adc_cfg_pkg::SEQ_CONTROL_IDX, 16'(n) << adc_cfg_pkg::REF_CONFIG_LSB);
			@(negedge clk);
			chk({14'h0, ref_p, ref_n}, (n == 1) ? 16'h2 : (n == 2) ? 16'h1 : (n == 3) ? 16'h3 : 16'h0);
		end
		// A positive code with no input behind it raises the error event.
		do_reset();
		wr_reg(adc_cfg_pkg::INPUT_SELECT_IDX, 16'h0012);
		rd_reg(adc_cfg_pkg::IRQ_STATUS_IDX, 16'h0002);
		// Split buffer, interrupt every fourth sequence, halves alternating.
		do_reset();
		wr_reg(adc_cfg_pkg::IRQ_MASK_IDX, 16'h0003);
		wr_reg(adc_cfg_pkg::SEQ_CONTROL_IDX, 16'h000e);
		conv(3);
		chk(st(0, 0, 4'h3, 0, 0), st(irq, fill, wptr, neg_an1, pos));
		conv(1);
		chk(st(1, 1, 4'h8, 0, 0), st(irq, fill, wptr, neg_an1, pos));
		rd_reg(adc_cfg_pkg::SEQ_CONTROL_IDX, 16'h008e);
		rd_reg(adc_cfg_pkg::IRQ_STATUS_IDX, 16'h0001);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
		conv(4);
		chk(st(1, 0, 4'h0, 0, 0), st(irq, fill, wptr, neg_an1, pos));
		wr_reg(adc_cfg_pkg::IRQ_MASK_IDX, 16'h0000);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
		rd_reg(adc_cfg_pkg::IRQ_STATUS_IDX, 16'h0001);
		// Single 16-word buffer with the slowest interrupt rate.
		do_reset();
		wr_reg(adc_cfg_pkg::IRQ_MASK_IDX, 16'h0001);
		wr_reg(adc_cfg_pkg::SEQ_CONTROL_IDX, 16'h003c);
		conv(15);
		chk(st(0, 0, 4'hf, 0, 0), st(irq, fill, wptr, neg_an1, pos));
		conv(1);
		chk(st(1, 0, 4'h0, 0, 0), st(irq, fill, wptr, neg_an1, pos));
		// Alternating multiplexer settings with distinct negative inputs.
		do_reset();
		wr_reg(adc_cfg_pkg::INPUT_SELECT_IDX, 16'h8905);
		wr_reg(adc_cfg_pkg::SEQ_CONTROL_IDX, 16'h003d);
		@(negedge clk);
		chk(st(0, 0, 4'h0, 0, 5'h05), st(irq, fill, wptr, neg_an1, pos));
		conv(1);
		chk(st(0, 0, 4'h1, 1, 5'h09), st(irq, fill, wptr, neg_an1, pos));
		conv(1);
		chk(st(0, 0, 4'h2, 0, 5'h05), st(irq, fill, wptr, neg_an1, pos));
		// Scan over channels 2, 7 and half band gap; band gap excluded.
		do_reset();
		wr_reg(adc_cfg_pkg::PIN_MODE_HIGH_IDX, 16'h0002);
		wr_reg(adc_cfg_pkg::SCAN_SELECT_IDX, 16'h0084);
		wr_reg(adc_cfg_pkg::SEQ_CONTROL_IDX, 16'h0408);
		@(negedge clk);
		chk({11'h0, pos}, 16'h0002);
		conv(1);
		chk({11'h0, pos}, 16'h0007);
		conv(1);
		chk({11'h0, pos}, 16'(adc_cfg_pkg::CODE_HALF_BANDGAP));
		conv(1);
		chk({11'h0, pos}, 16'h0002);
		// Divided clock: a tick every two oscillator periods times divider plus one.
		do_reset();
		wr_reg(adc_cfg_pkg::CLOCK_TIMING_IDX, 16'h0302);
		i = 0;
		do begin @(negedge clk); i++; end while (tad !== 1'b1 && i < 100);
		i = 0;
		do begin @(negedge clk); i++; end while (tad !== 1'b1 && i < 100);
		chk(16'(i), 16'd6);
		// RC clock source drives the sample timer for three ticks.
		wr_reg(adc_cfg_pkg::CLOCK_TIMING_IDX, 16'h8300);
		i_core.start_sample();
		n = 0;
		i = 0;
		while (s_end !== 1'b1 && i < 200)
		begin
			@(negedge clk);
			chk({15'h0, tad}, {15'h0, rc_tick});
			if (tad === 1'b1)
				n++;
			i++;
		end
		chk(16'(n), 16'd3);
		chk({15'h0, s_end}, 16'h0001);
		repeat (3) @(posedge clk);
		report_and_stop();
	end
endmodule
